// ===== src/bmpa_pkg.sv
package bmpa_pkg;
    localparam int BMPA_NM  = 11;
    localparam int BMPA_PW  = 3;
    localparam int BMPA_IDW = 6;
    localparam int BMPA_AW  = 8;

    // Master slots, ordered by rising identifier
    localparam int BMPA_IX_CPU_PROG = 0;
    localparam int BMPA_IX_CPU_DATA = 1;
    localparam int BMPA_IX_VIDEO    = 2;
    localparam int BMPA_IX_DMA      = 3;
    localparam int BMPA_IX_C0_RD    = 4;
    localparam int BMPA_IX_C1_WR    = 7;
    localparam int BMPA_IX_ETH      = 8;
    localparam int BMPA_IX_USB      = 9;
    localparam int BMPA_IX_HOST     = 10;

    localparam logic [BMPA_IDW-1:0] BMPA_MSTID [BMPA_NM] = '{
        6'h00, 6'h01, 6'h08, 6'h0a, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20, 6'h22, 6'h25};

    // Slots that drive their own priority on the request port
    localparam logic [BMPA_NM-1:0] BMPA_OWN_PRI = 11'h0f8;

    localparam logic [BMPA_AW-1:0] BMPA_OFS_CTRL  = 8'h00;
    localparam logic [BMPA_AW-1:0] BMPA_OFS_STAT  = 8'h04;
    localparam logic [BMPA_AW-1:0] BMPA_OFS_MPRI0 = 8'h3c;
    localparam logic [BMPA_AW-1:0] BMPA_OFS_MPRI1 = 8'h40;
    localparam logic [BMPA_AW-1:0] BMPA_OFS_VPCR  = 8'h50;

    localparam int BMPA_POS_CPU_PROG = 0;
    localparam int BMPA_POS_CPU_DATA = 4;
    localparam int BMPA_POS_ETH      = 0;
    localparam int BMPA_POS_USB      = 4;
    localparam int BMPA_POS_HOST     = 8;
    localparam int BMPA_POS_DYN      = 0;

    localparam logic [31:0] BMPA_CTRL_RST  = 32'h0000_0001;
    localparam logic [31:0] BMPA_MPRI0_RST = 32'h0000_0011;
    localparam logic [31:0] BMPA_MPRI1_RST = 32'h0000_0444;
    localparam logic [31:0] BMPA_VPCR_RST  = 32'h0000_0000;
    localparam logic [31:0] BMPA_CTRL_MSK  = 32'h0000_0001;
    localparam logic [31:0] BMPA_MPRI0_MSK = 32'h0000_0077;
    localparam logic [31:0] BMPA_MPRI1_MSK = 32'h0000_0777;
    localparam logic [31:0] BMPA_VPCR_MSK  = 32'h0000_0007;

    localparam logic [1:0] BMPA_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BMPA_RESP_SLVERR = 2'h2;

    function automatic logic bmpa_is_reserved(input logic [BMPA_IDW-1:0] id);
        return !(id inside {6'h00, 6'h01, 6'h08, 6'h0a, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20, 6'h22, 6'h25});
    endfunction : bmpa_is_reserved

    // With dyn set, lower value wins and equal values go to the lower slot; with dyn clear the lowest requesting slot wins
    function automatic logic [BMPA_NM-1:0] bmpa_pick(input logic [BMPA_NM-1:0]              req,
                                                     input logic [BMPA_NM-1:0][BMPA_PW-1:0] pri,
                                                     input logic                            dyn);
        logic [BMPA_NM-1:0] g;
        logic [BMPA_PW-1:0] best;
        logic               found;
        g     = '0;
        best  = '1;
        found = 1'b0;
        for (int i = 0; i < BMPA_NM; i++) begin
            if (req[i] && (!found || (dyn && pri[i] < best))) begin
                g     = '0;
                g[i]  = 1'b1;
                best  = pri[i];
                found = 1'b1;
            end
        end
        return g;
    endfunction : bmpa_pick

    function automatic logic [BMPA_IDW-1:0] bmpa_id_of(input logic [BMPA_NM-1:0] g);
        logic [BMPA_IDW-1:0] id;
        id = '0;
        for (int i = 0; i < BMPA_NM; i++) begin
            if (g[i]) begin
                id = id | BMPA_MSTID[i];
            end
        end
        return id;
    endfunction : bmpa_id_of
endpackage : bmpa_pkg

// ===== src/bmpa_pri.sv
`timescale 1ns/1ns
`default_nettype none
module bmpa_pri
    import bmpa_pkg::*;
(
    input  wire logic [BMPA_NM-1:0][BMPA_PW-1:0] m_pri,
    input  wire logic [31:0]                     mpri0,
    input  wire logic [31:0]                     mpri1,
    input  wire logic [31:0]                     vpcr,
    output logic      [BMPA_NM-1:0][BMPA_PW-1:0] eff_pri
);
    genvar g;
    generate
        for (g = 0; g < BMPA_NM; g++) begin : g_own
            if (BMPA_OWN_PRI[g]) begin : g_pin
                assign eff_pri[g] = m_pri[g];
            end
        end
    endgenerate

    assign eff_pri[BMPA_IX_CPU_PROG] = mpri0[BMPA_POS_CPU_PROG +: BMPA_PW];
    assign eff_pri[BMPA_IX_CPU_DATA] = mpri0[BMPA_POS_CPU_DATA +: BMPA_PW];
    assign eff_pri[BMPA_IX_VIDEO]    = vpcr[BMPA_PW-1:0];
    assign eff_pri[BMPA_IX_ETH]      = mpri1[BMPA_POS_ETH +: BMPA_PW];
    assign eff_pri[BMPA_IX_USB]      = mpri1[BMPA_POS_USB +: BMPA_PW];
    assign eff_pri[BMPA_IX_HOST]     = mpri1[BMPA_POS_HOST +: BMPA_PW];
endmodule : bmpa_pri
`default_nettype wire

// ===== src/bmpa_arb.sv
`timescale 1ns/1ns
`default_nettype none
module bmpa_arb
    import bmpa_pkg::*;
(
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic                            dyn,
    input  wire logic [BMPA_NM-1:0]              req,
    input  wire logic [BMPA_NM-1:0][BMPA_PW-1:0] pri,
    output logic      [BMPA_NM-1:0]              gnt_ff,
    output logic      [BMPA_IDW-1:0]             id_ff
);
    logic               hold;
    logic [BMPA_NM-1:0] pick;
    logic [BMPA_NM-1:0] nxt_gnt;

    // Grant stays with its owner while it keeps requesting
    assign hold    = |(gnt_ff & req);
    assign pick    = bmpa_pick(req, pri, dyn);
    assign nxt_gnt = hold ? gnt_ff : pick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gnt_ff <= '0;
            id_ff  <= '0;
        end else begin
            gnt_ff <= nxt_gnt;
            id_ff  <= bmpa_id_of(nxt_gnt);
        end
    end
endmodule : bmpa_arb
`default_nettype wire

// ===== src/bmpa_top.sv
`timescale 1ns/1ns
`default_nettype none
module bmpa_top
    import bmpa_pkg::*;
#(
    parameter int                                 NUM_SP   = 2,
    parameter logic [NUM_SP-1:0][BMPA_NM-1:0]     SP_ALLOW = '1,
    localparam int                                SPW      = (NUM_SP > 1) ? $clog2(NUM_SP) : 1
) (
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [BMPA_AW-1:0]               s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [BMPA_AW-1:0]               s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    input  wire logic [BMPA_NM-1:0]               m_req,
    input  wire logic [BMPA_NM-1:0][SPW-1:0]      m_sp,
    input  wire logic [BMPA_NM-1:0][BMPA_PW-1:0]  m_pri,
    output logic      [NUM_SP-1:0][BMPA_NM-1:0]   sp_gnt,
    output logic      [NUM_SP-1:0][BMPA_IDW-1:0]  sp_gnt_id,
    output logic      [BMPA_NM-1:0]               m_deny
);
    // Refused at elaboration: the status word and the target decode serve 2 to 16 points
    if (NUM_SP < 2 || NUM_SP > 16) begin : g_bad_num_sp
        $error("NUM_SP must be between 2 and 16");
    end

    logic [31:0]               ctrl_ff;
    logic [31:0]               mpri0_ff;
    logic [31:0]               mpri1_ff;
    logic [31:0]               vpcr_ff;
    logic                      aw_full_ff;
    logic                      w_full_ff;
    logic [BMPA_AW-1:0]        waddr_ff;
    logic [31:0]               wdata_ff;
    logic [3:0]                wstrb_ff;
    logic                      awready_ff;
    logic                      wready_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      arready_ff;
    logic                      rvalid_ff;
    logic [31:0]               rdata_ff;
    logic [1:0]                rresp_ff;
    logic [BMPA_NM-1:0]        deny_ff;

    function automatic logic bmpa_mapped(input logic [BMPA_AW-1:0] a);
        return a inside {BMPA_OFS_CTRL, BMPA_OFS_STAT, BMPA_OFS_MPRI0, BMPA_OFS_MPRI1, BMPA_OFS_VPCR};
    endfunction : bmpa_mapped

    function automatic logic [31:0] bmpa_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb, input logic [31:0] msk);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r & msk;
    endfunction : bmpa_merge

    // Write channel: address and data taken in either order
    logic        aw_take;
    logic        w_take;
    logic        do_wr;
    logic        nxt_aw_full;
    logic        nxt_w_full;
    logic        nxt_bvalid;
    logic        wr_ctrl;
    logic        wr_mpri0;
    logic        wr_mpri1;
    logic        wr_vpcr;

    assign aw_take     = s_axi_awvalid && awready_ff;
    assign w_take      = s_axi_wvalid && wready_ff;
    assign do_wr       = aw_full_ff && w_full_ff && !bvalid_ff;
    assign nxt_aw_full = aw_full_ff ? !do_wr : aw_take;
    assign nxt_w_full  = w_full_ff ? !do_wr : w_take;
    assign nxt_bvalid  = do_wr || (bvalid_ff && !s_axi_bready);
    assign wr_ctrl     = do_wr && waddr_ff == BMPA_OFS_CTRL;
    assign wr_mpri0    = do_wr && waddr_ff == BMPA_OFS_MPRI0;
    assign wr_mpri1    = do_wr && waddr_ff == BMPA_OFS_MPRI1;
    assign wr_vpcr     = do_wr && waddr_ff == BMPA_OFS_VPCR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            waddr_ff   <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= BMPA_RESP_OKAY;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready_ff <= !nxt_aw_full && !nxt_bvalid;
            wready_ff  <= !nxt_w_full && !nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            if (aw_take) begin
                waddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                bresp_ff <= bmpa_mapped(waddr_ff) ? BMPA_RESP_OKAY : BMPA_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff  <= BMPA_CTRL_RST;
            mpri0_ff <= BMPA_MPRI0_RST;
            mpri1_ff <= BMPA_MPRI1_RST;
            vpcr_ff  <= BMPA_VPCR_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= bmpa_merge(ctrl_ff, wdata_ff, wstrb_ff, BMPA_CTRL_MSK);
            end
            if (wr_mpri0) begin
                mpri0_ff <= bmpa_merge(mpri0_ff, wdata_ff, wstrb_ff, BMPA_MPRI0_MSK);
            end
            if (wr_mpri1) begin
                mpri1_ff <= bmpa_merge(mpri1_ff, wdata_ff, wstrb_ff, BMPA_MPRI1_MSK);
            end
            if (wr_vpcr) begin
                vpcr_ff <= bmpa_merge(vpcr_ff, wdata_ff, wstrb_ff, BMPA_VPCR_MSK);
            end
        end
    end

    // Read channel
    logic              ar_take;
    logic              nxt_rvalid;
    logic [NUM_SP-1:0] sp_busy;
    logic [31:0]       stat_word;
    logic [31:0]       rd_word;

    assign ar_take    = s_axi_arvalid && arready_ff;
    assign nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);
    assign stat_word  = 32'(sp_busy);
    assign rd_word    = (s_axi_araddr == BMPA_OFS_CTRL)  ? ctrl_ff :
                        (s_axi_araddr == BMPA_OFS_STAT)  ? stat_word :
                        (s_axi_araddr == BMPA_OFS_MPRI0) ? mpri0_ff :
                        (s_axi_araddr == BMPA_OFS_MPRI1) ? mpri1_ff :
                        (s_axi_araddr == BMPA_OFS_VPCR)  ? vpcr_ff : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= BMPA_RESP_OKAY;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= bmpa_mapped(s_axi_araddr) ? BMPA_RESP_OKAY : BMPA_RESP_SLVERR;
            end
        end
    end

    // Priority sources and switching points
    logic [BMPA_NM-1:0][BMPA_PW-1:0] eff_pri;
    logic [NUM_SP-1:0][BMPA_NM-1:0]  sp_req;
    logic [BMPA_NM-1:0]              nxt_deny;
    logic                            dyn;

    assign dyn = ctrl_ff[BMPA_POS_DYN];

    bmpa_pri u_pri (
        .m_pri   (m_pri),
        .mpri0   (mpri0_ff),
        .mpri1   (mpri1_ff),
        .vpcr    (vpcr_ff),
        .eff_pri (eff_pri)
    );

    genvar s;
    genvar m;
    generate
        for (m = 0; m < BMPA_NM; m++) begin : g_deny
            assign nxt_deny[m] = m_req[m] && !(32'(m_sp[m]) < NUM_SP && SP_ALLOW[m_sp[m]][m]);
        end
        for (s = 0; s < NUM_SP; s++) begin : g_sp
            for (m = 0; m < BMPA_NM; m++) begin : g_req
                assign sp_req[s][m] = m_req[m] && m_sp[m] == SPW'(s) && SP_ALLOW[s][m];
            end
            bmpa_arb u_arb (
                .aclk    (aclk),
                .aresetn (aresetn),
                .dyn     (dyn),
                .req     (sp_req[s]),
                .pri     (eff_pri),
                .gnt_ff  (sp_gnt[s]),
                .id_ff   (sp_gnt_id[s])
            );
            assign sp_busy[s] = |sp_gnt[s];

            AST_ONEHOT: assert property (@(posedge aclk) disable iff (!aresetn) $onehot0(sp_gnt[s]))
                else $error("more than one grant at a switching point");
            AST_ALLOW: assert property (@(posedge aclk) disable iff (!aresetn)
                (sp_gnt[s] & ~SP_ALLOW[s]) == '0)
                else $error("grant to a master not permitted here");
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deny_ff <= '0;
        end else begin
            deny_ff <= nxt_deny;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign m_deny        = deny_ff;

    // Helpers for checking the winner at switching point 0
    logic [BMPA_NM-1:0][BMPA_PW-1:0] pri_q;
    logic [BMPA_PW-1:0]              min_pri;
    logic [BMPA_PW-1:0]              gnt_pri;

    always_ff @(posedge aclk) begin
        pri_q <= eff_pri;
    end

    always_comb begin
        min_pri = '1;
        gnt_pri = '0;
        for (int i = 0; i < BMPA_NM; i++) begin
            if (sp_req[0][i] && eff_pri[i] < min_pri) begin
                min_pri = eff_pri[i];
            end
            if (sp_gnt[0][i]) begin
                gnt_pri = pri_q[i];
            end
        end
    end

    AST_ID_CPU: assert property (@(posedge aclk) disable iff (!aresetn)
        sp_gnt[0][BMPA_IX_CPU_DATA] |-> sp_gnt_id[0] == 6'h01 && !bmpa_is_reserved(sp_gnt_id[0]))
        else $error("processor data port carries the wrong identifier");
    AST_ID_DMA: assert property (@(posedge aclk) disable iff (!aresetn)
        sp_gnt[0][BMPA_IX_DMA] |-> sp_gnt_id[0] == 6'h0a)
        else $error("DMA controller carries the wrong identifier");
    AST_ID_CHAN: assert property (@(posedge aclk) disable iff (!aresetn)
        sp_gnt[0][BMPA_IX_C1_WR] |-> sp_gnt_id[0] == 6'h13)
        else $error("DMA channel 1 write carries the wrong identifier");
    AST_ID_HOST: assert property (@(posedge aclk) disable iff (!aresetn)
        sp_gnt[0][BMPA_IX_HOST] |-> sp_gnt_id[0] == 6'h25)
        else $error("host port carries the wrong identifier");
    AST_RST_PRI: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> eff_pri[BMPA_IX_CPU_PROG] == 3'h1 && eff_pri[BMPA_IX_ETH] == 3'h4
                            && eff_pri[BMPA_IX_HOST] == 3'h4)
        else $error("master priorities wrong after reset");
    AST_VPCR_RST: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> eff_pri[BMPA_IX_VIDEO] == 3'h0)
        else $error("video priority not zero after reset");
    AST_SW_PRI: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mpri1 && wstrb_ff[0] |=> eff_pri[BMPA_IX_ETH] == $past(wdata_ff[2:0]))
        else $error("Ethernet priority not taken from its register");
    AST_OWN_PRI: assert property (@(posedge aclk) disable iff (!aresetn)
        eff_pri[BMPA_IX_C0_RD] == m_pri[BMPA_IX_C0_RD])
        else $error("DMA channel priority not taken from its port");
    AST_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
        !dyn && !sp_busy[0] && |sp_req[0] |=> sp_gnt[0] == $past(sp_req[0] & (~sp_req[0] + 11'h001)))
        else $error("fixed order did not pick the lowest identifier");
    AST_DYN: assert property (@(posedge aclk) disable iff (!aresetn)
        dyn && !sp_busy[0] && |sp_req[0] |=> gnt_pri == $past(min_pri))
        else $error("dynamic order did not pick the lowest priority value");
    AST_SLVERR: assert property (@(posedge aclk) disable iff (!aresetn)
        do_wr && !bmpa_mapped(waddr_ff) |=> s_axi_bvalid && s_axi_bresp == BMPA_RESP_SLVERR)
        else $error("unmapped write not answered with an error");
endmodule : bmpa_top
`default_nettype wire

// ===== verif/bmpa_masters.sv
`timescale 1ns/1ns
`default_nettype none
module bmpa_masters
    import bmpa_pkg::*;
#(
    parameter int SPW = 1
) (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [BMPA_NM-1:0]              want,
    input  wire logic [BMPA_NM-1:0][SPW-1:0]     sp_sel,
    input  wire logic [BMPA_NM-1:0][BMPA_PW-1:0] own_pri,
    output logic      [BMPA_NM-1:0]              req_ff,
    output logic      [BMPA_NM-1:0][SPW-1:0]     sp_ff,
    output logic      [BMPA_NM-1:0][BMPA_PW-1:0] pri_ff
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_ff <= '0;
            sp_ff  <= '0;
            pri_ff <= '0;
        end else begin
            req_ff <= want;
            sp_ff  <= sp_sel;
            for (int i = 0; i < BMPA_NM; i++) begin
                // Masters without their own priority leave it floating: churn it
                pri_ff[i] <= BMPA_OWN_PRI[i] ? own_pri[i] : ~pri_ff[i];
            end
        end
    end
endmodule : bmpa_masters
`default_nettype wire

// ===== verif/tb_bus_master_priority_arbitration.sv
`timescale 1ns/1ns
`default_nettype none
module tb_bus_master_priority_arbitration
    import bmpa_pkg::*;
;
    logic                            aclk          = 1'b0;
    logic                            aresetn       = 1'b0;
    logic [7:0]                      s_axi_awaddr  = '0;
    logic                            s_axi_awvalid = 1'b0;
    logic [31:0]                     s_axi_wdata   = '0;
    logic                            s_axi_wvalid  = 1'b0;
    logic                            s_axi_bready  = 1'b0;
    logic [7:0]                      s_axi_araddr  = '0;
    logic                            s_axi_arvalid = 1'b0;
    logic                            s_axi_rready  = 1'b0;
    logic                            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]                      s_axi_bresp, s_axi_rresp;
    logic [31:0]                     s_axi_rdata;
    logic [BMPA_NM-1:0]              want          = '0;
    logic [BMPA_NM-1:0][0:0]         sp_sel        = '0;
    logic [BMPA_NM-1:0][BMPA_PW-1:0] own_pri       = '0;
    logic [BMPA_NM-1:0]              m_req, m_deny;
    logic [BMPA_NM-1:0][0:0]         m_sp;
    logic [BMPA_NM-1:0][BMPA_PW-1:0] m_pri;
    logic [1:0][BMPA_NM-1:0]         sp_gnt;
    logic [1:0][BMPA_IDW-1:0]        sp_gnt_id;
    int                              err_total     = 0;
    int                              comparisons   = 0;
    localparam logic [5:0] IDS [11] = '{6'h00, 6'h01, 6'h08, 6'h0a, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20, 6'h22, 6'h25};

    always #50 aclk = ~aclk;

    bmpa_top #(.NUM_SP(2), .SP_ALLOW({11'h5ff, 11'h7ff})) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .m_req(m_req), .m_sp(m_sp), .m_pri(m_pri),
        .sp_gnt(sp_gnt), .sp_gnt_id(sp_gnt_id), .m_deny(m_deny));

    bmpa_masters #(.SPW(1)) masters (
        .aclk(aclk), .aresetn(aresetn), .want(want), .sp_sel(sp_sel), .own_pri(own_pri),
        .req_ff(m_req), .sp_ff(m_sp), .pri_ff(m_pri));

    task automatic summarize();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd

    // Requests travel one cycle through the masters, grant lands one cycle later
    task automatic arb(input logic [10:0] w, input logic [10:0] s, input int sp, input logic [10:0] eg);
        logic [5:0] eid;
        eid    = '0;
        want   <= w;
        sp_sel <= s;
        repeat (3) @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            if (eg[i]) eid = IDS[i];
        end
        chk(sp_gnt[sp], eg);
        chk(sp_gnt_id[sp], eid);
    endtask : arb

    task automatic idle();
        want <= '0;
        repeat (3) @(posedge aclk);
    endtask : idle

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h00, 32'h1, 2'h0);
        rd(8'h3c, 32'h11, 2'h0);
        rd(8'h40, 32'h444, 2'h0);
        rd(8'h50, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h2);
        wr(8'h0c, 32'h5, 2'h2);
        wr(8'h40, 32'hffffffff, 2'h0);
        rd(8'h40, 32'h777, 2'h0);
        wr(8'h40, 32'h444, 2'h0);
        for (int i = 0; i < 11; i++) begin
            arb(11'h1 << i, '0, 0, 11'h1 << i);
            idle();
        end
        wr(8'h3c, 32'h15, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        arb(11'h101, '0, 0, 11'h001);
        arb(11'h100, '0, 0, 11'h100);
        idle();
        wr(8'h00, 32'h1, 2'h0);
        arb(11'h101, '0, 0, 11'h100);
        idle();
        own_pri[4] <= 3'h2;
        own_pri[3] <= 3'h6;
        arb(11'h018, '0, 0, 11'h010);
        idle();
        own_pri[3] <= 3'h1;
        arb(11'h018, '0, 0, 11'h008);
        idle();
        own_pri[4] <= 3'h3;
        own_pri[5] <= 3'h3;
        arb(11'h030, '0, 0, 11'h010);
        idle();
        arb(11'h006, '0, 0, 11'h004);
        idle();
        wr(8'h50, 32'h7, 2'h0);
        arb(11'h006, '0, 0, 11'h002);
        idle();
        arb(11'h101, 11'h100, 1, 11'h100);
        chk(sp_gnt[0], 11'h001);
        rd(8'h04, 32'h3, 2'h0);
        idle();
        arb(11'h200, 11'h200, 1, 11'h000);
        chk(m_deny, 11'h200);
        idle();
        // Reset in mid-run must bring back the default priorities
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h3c, 32'h11, 2'h0);
        rd(8'h50, 32'h0, 2'h0);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        summarize();
    end
endmodule : tb_bus_master_priority_arbitration
`default_nettype wire
